// ### frs_map.vh
`ifndef FRS_MAP_VH
`define FRS_MAP_VH

// =====================================================
// Source channel codes
`define FRS_SRC_DIG_VOL   4'h0
`define FRS_SRC_DIG_RET   4'h1
`define FRS_SRC_AIN1      4'h2
`define FRS_SRC_AIN2      4'h3
`define FRS_SRC_AIN3      4'h4
`define FRS_SRC_PULSE     4'h5
`define FRS_SRC_MULTI     4'h6
`define FRS_SRC_SEQ       4'h7
`define FRS_SRC_LOOP      4'h8
`define FRS_SRC_COMM      4'h9

// =====================================================
// Combine selector digits
`define FRS_UNIT_LO       0
`define FRS_TENS_LO       4
`define FRS_U_MAIN        4'h0
`define FRS_U_COMB        4'h1
`define FRS_U_SW_XY       4'h2
`define FRS_U_SW_XC       4'h3
`define FRS_U_SW_YC       4'h4
`define FRS_T_SUM         4'h0
`define FRS_T_DIFF        4'h1
`define FRS_T_MAX         4'h2
`define FRS_T_MIN         4'h3

// =====================================================
// Scaling and reset values (frequency in 0.01 Hz)
`define FRS_PCT_FULL      34'sh00000_2710
`define FRS_RANGE_DIV     25'h000064
`define FRS_RANGE_MAX     8'h96
`define FRS_PRESET_RST    16'h1388

`endif

// ### frs_updown.v
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Up/down adjusted setpoint, clamped to 0..limit
module frs_updown
(
   input  wire        mclk,
   input  wire        rst,
   input  wire        load,
   input  wire [15:0] load_value,
   input  wire        up,
   input  wire        down,
   input  wire [15:0] step,
   input  wire [15:0] limit,
   output wire [15:0] value
);

   reg  [15:0] value_q;
   reg  [16:0] sum;
   reg  [15:0] value_d;

   // Next value with saturation at both ends
   always @*
   begin
      sum = {1'b0, value_q} + {1'b0, step};
      value_d = value_q;
      if (load)
         value_d = (load_value > limit) ? limit : load_value;
      else if (up && !down)
         value_d = (sum > {1'b0, limit}) ? limit : sum[15:0];
      else if (down && !up)
         value_d = (value_q > step) ? value_q - step : 16'h0000;
      else if (value_q > limit)
         value_d = limit;
   end

   // Setpoint register
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         value_q <= 16'h0000;
      else
         value_q <= value_d;
   end

   assign value = value_q;

endmodule
`default_nettype wire

// ### frs_selector.v
`timescale 1ns/1ps
`default_nettype none
`include "frs_map.vh"
// =====================================================
// Target frequency selector
module frs_selector
(
   input  wire        mclk,
   input  wire        rst,
   input  wire [3:0]  main_source_select,
   input  wire [3:0]  aux_source_select,
   input  wire        aux_range_base,
   input  wire [7:0]  aux_range_percent,
   input  wire [7:0]  source_combine_select,
   input  wire [15:0] preset_frequency,
   input  wire        direction_invert,
   input  wire [15:0] maximum_frequency,
   input  wire [15:0] combine_offset_frequency,
   input  wire [15:0] analog_input_one,
   input  wire [15:0] analog_input_two,
   input  wire [15:0] analog_input_three,
   input  wire [15:0] pulse_input_terminal,
   input  wire [15:0] multi_reference_pct,
   input  wire [15:0] sequencer_pct,
   input  wire [15:0] closed_loop_pct,
   input  wire [15:0] comm_value,
   input  wire        comm_p2p_slave,
   input  wire        freq_switch,
   input  wire        up_pulse,
   input  wire        down_pulse,
   input  wire [15:0] updown_step,
   input  wire [15:0] retained_frequency,
   output wire [19:0] target_frequency,
   output wire        reverse_dir,
   output wire        config_error,
   output wire [15:0] digital_setting
);

   // =====================================================
   // Declarations
   reg         init_q;
   reg  [19:0] target_q;
   reg         reverse_q;
   reg         error_q;
   wire [15:0] dig_val;
   wire [15:0] trim_val;
   wire [3:0]  unit_dig;
   wire [3:0]  tens_dig;
   wire        comb_active;
   wire        aux_digital;
   wire        any_retained;
   wire [15:0] dig_load_val;
   wire [16:0] range_base;
   wire [7:0]  range_pct;
   wire [24:0] range_prod;
   wire [16:0] aux_range;
   wire [24:0] range_quo;
   wire [19:0] x_abs;
   wire [127:0] pct_bus;
   reg  signed [19:0] x_val;
   reg  signed [19:0] y_ind;
   reg  signed [19:0] y_cmb;
   reg  signed [19:0] comb_raw;
   reg  signed [19:0] comb_res;
   reg  signed [19:0] sel_val;
   reg  signed [19:0] ax;
   reg  signed [19:0] ay;

   // =====================================================
   // Helper functions
   // Signed percent (10000 = 100 %) times an unsigned base
   // Quotient truncates toward zero, like the range scaling
   function signed [19:0] pct_scale;
      input [15:0] pct;
      input [16:0] base;
      reg signed [33:0] prod;
      begin
         prod = $signed(pct) * $signed({1'b0, base});
         prod = prod / `FRS_PCT_FULL;
         pct_scale = prod[19:0];
      end
   endfunction

   // Absolute value of a combined quantity
   function signed [19:0] abs_val;
      input signed [19:0] v;
      begin
         abs_val = v[19] ? -v : v;
      end
   endfunction

   // Percent carried by a non-digital channel code
   // Slot order follows the packed channel bus
   function [15:0] chan_pct;
      input [3:0]   code;
      input [127:0] bus;
      begin
         case (code)
            `FRS_SRC_AIN1:  chan_pct = bus[15:0];
            `FRS_SRC_AIN2:  chan_pct = bus[31:16];
            `FRS_SRC_AIN3:  chan_pct = bus[47:32];
            `FRS_SRC_PULSE: chan_pct = bus[63:48];
            `FRS_SRC_MULTI: chan_pct = bus[79:64];
            `FRS_SRC_SEQ:   chan_pct = bus[95:80];
            `FRS_SRC_LOOP:  chan_pct = bus[111:96];
            `FRS_SRC_COMM:  chan_pct = bus[127:112];
            default:        chan_pct = 16'h0000;
         endcase
      end
   endfunction

   // Independent channel value, same path for main and auxiliary
   // Every operand is an argument, so the caller's sensitivity sees it
   function signed [19:0] chan_freq;
      input [3:0]   code;
      input [127:0] bus;
      input [15:0]  dig;
      input         slave;
      input [15:0]  mx;
      begin
         case (code)
            `FRS_SRC_DIG_VOL,
            `FRS_SRC_DIG_RET:
               chan_freq = {4'h0, dig};
            `FRS_SRC_COMM:
               // Slave takes the master's frequency as is
               chan_freq = slave ? {4'h0, bus[127:112]}
                         : pct_scale(bus[127:112], {1'b0, mx});
            default:
               // Full scale spans maximum frequency
               chan_freq = pct_scale(chan_pct(code, bus), {1'b0, mx});
         endcase
      end
   endfunction

   // =====================================================
   // Selector digits and mode decode
   assign unit_dig = source_combine_select[`FRS_UNIT_LO +: 4];
   assign tens_dig = source_combine_select[`FRS_TENS_LO +: 4];
   assign aux_digital = (aux_source_select == `FRS_SRC_DIG_VOL) ||
                        (aux_source_select == `FRS_SRC_DIG_RET);
   // Combined result currently feeds the target
   assign comb_active = (unit_dig == `FRS_U_COMB) ||
                        ((unit_dig == `FRS_U_SW_XC) && freq_switch) ||
                        ((unit_dig == `FRS_U_SW_YC) && freq_switch);

   // =====================================================
   // Digital setpoint and up/down trim
   assign any_retained = (main_source_select == `FRS_SRC_DIG_RET) ||
                         (aux_source_select == `FRS_SRC_DIG_RET);
   // Power-up value: memorised or preset
   assign dig_load_val = any_retained ? retained_frequency : preset_frequency;

   // First cycle after reset release loads the start value
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         init_q <= 1'b0;
      else
         init_q <= 1'b1;
   end

   // Digital setpoint, starts from the retained value if either channel selects it, else the preset value
   frs_updown u_digital
   (
      .mclk       (mclk),
      .rst        (rst),
      .load       (!init_q),
      .load_value (dig_load_val),
      .up         (up_pulse && !(comb_active && aux_digital)),
      .down       (down_pulse && !(comb_active && aux_digital)),
      .step       (updown_step),
      .limit      (maximum_frequency),
      .value      (dig_val)
   );

   // Trim on the auxiliary value, preset ignored, starts at zero
   frs_updown u_trim
   (
      .mclk       (mclk),
      .rst        (rst),
      .load       (!init_q),
      .load_value (16'h0000),
      .up         (up_pulse && comb_active && aux_digital),
      .down       (down_pulse && comb_active && aux_digital),
      .step       (updown_step),
      .limit      (maximum_frequency),
      .value      (trim_val)
   );

   // =====================================================
   // Channel percentages packed for the decode functions
   assign pct_bus = {comm_value, closed_loop_pct, sequencer_pct, multi_reference_pct,
                     pulse_input_terminal, analog_input_three, analog_input_two,
                     analog_input_one};

   // =====================================================
   // Main and switched-in auxiliary values
   // Sensitivity does not reach into functions, hence explicit operands
   always @*
   begin
      // Main value from its own channel
      x_val = chan_freq(main_source_select, pct_bus, dig_val, comm_p2p_slave, maximum_frequency);
      // Switched-in auxiliary uses the main decode
      y_ind = chan_freq(aux_source_select, pct_bus, dig_val, comm_p2p_slave, maximum_frequency);
   end

   // =====================================================
   // Auxiliary range for combined operation
   // Main magnitude, saturated to the range base width
   assign x_abs = abs_val(x_val);
   // Base is maximum frequency or the main magnitude
   assign range_base = aux_range_base ? ((|x_abs[19:17]) ? 17'h1ffff : x_abs[16:0])
                     : {1'b0, maximum_frequency};
   // Percentage clamped to its legal top
   assign range_pct = (aux_range_percent > `FRS_RANGE_MAX) ?
                      `FRS_RANGE_MAX : aux_range_percent;
   assign range_prod = {8'h00, range_base} * {17'h00000, range_pct};
   // Quotient taken on the full product before narrowing
   assign range_quo = range_prod / `FRS_RANGE_DIV;
   assign aux_range = (range_quo > 25'h001ffff) ? 17'h1ffff : range_quo[16:0];

   // =====================================================
   // Auxiliary as operand of combined operation
   always @*
   begin
      case (aux_source_select)
         `FRS_SRC_DIG_VOL,
         `FRS_SRC_DIG_RET:
            y_cmb = {4'h0, trim_val};
         `FRS_SRC_COMM:
            y_cmb = comm_p2p_slave ? {4'h0, comm_value}
                  : pct_scale(comm_value, aux_range);
         `FRS_SRC_AIN1, `FRS_SRC_AIN2, `FRS_SRC_AIN3, `FRS_SRC_PULSE,
         `FRS_SRC_MULTI, `FRS_SRC_SEQ, `FRS_SRC_LOOP:
            y_cmb = pct_scale(chan_pct(aux_source_select, pct_bus), aux_range);
         default:
            y_cmb = 20'sh00000;
      endcase
   end

   // =====================================================
   // Combined result and target source choice
   always @*
   begin
      // Magnitudes for max and min; ties keep the main value
      ax = abs_val(x_val);
      ay = abs_val(y_cmb);
      // Operation chosen by the tens digit
      case (tens_dig)
         `FRS_T_SUM:  comb_raw = x_val + y_cmb;
         `FRS_T_DIFF: comb_raw = x_val - y_cmb;
         `FRS_T_MAX:  comb_raw = (ax >= ay) ? x_val : y_cmb;
         `FRS_T_MIN:  comb_raw = (ax <= ay) ? x_val : y_cmb;
         default:     comb_raw = x_val;
      endcase
      // Offset superimposed on the combined result
      comb_res = comb_raw + $signed({4'h0, combine_offset_frequency});
      // Target source chosen by the units digit
      case (unit_dig)
         `FRS_U_MAIN:  sel_val = x_val;
         `FRS_U_COMB:  sel_val = comb_res;
         `FRS_U_SW_XY: sel_val = freq_switch ? y_ind : x_val;
         `FRS_U_SW_XC: sel_val = freq_switch ? comb_res : x_val;
         `FRS_U_SW_YC: sel_val = freq_switch ? comb_res : y_ind;
         default:      sel_val = x_val;
      endcase
   end

   // =====================================================
   // Registered target, direction and configuration check
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         target_q  <= 20'h00000;
         reverse_q <= 1'b0;
         error_q   <= 1'b0;
      end
      else if (main_source_select == aux_source_select)
      begin
         // Same channel twice: hold zero and flag it
         target_q  <= 20'h00000;
         reverse_q <= 1'b0;
         error_q   <= 1'b1;
      end
      else
      begin
         target_q  <= abs_val(sel_val);
         // Sign of the request, inverted on demand
         reverse_q <= sel_val[19] ^ direction_invert;
         error_q   <= 1'b0;
      end
   end

   // Outputs straight from their registers
   assign target_frequency = target_q;
   assign reverse_dir      = reverse_q;
   assign config_error     = error_q;
   assign digital_setting  = dig_val;

endmodule
`default_nettype wire

// ### frs_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Setpoint source channels, loaded one at a time
module frs_src_model
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        load,
   input  wire logic [2:0]  idx,
   input  wire logic [15:0] value,
   output var  logic [15:0] ch [0:6]
);
   // Channels cleared in reset, then updated on request
   always @(posedge mclk)
   begin
      if (rst)
      begin
         foreach (ch[i])
            ch[i] <= 16'h0;
      end
      else if (load)
      begin
         ch[idx] <= value;
      end
   end
endmodule
`default_nettype wire

// ### frs_chk.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Selector port checker
module frs_chk
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [3:0]  main_source_select,
   input wire logic [3:0]  aux_source_select,
   input wire logic        aux_range_base,
   input wire logic [7:0]  aux_range_percent,
   input wire logic [7:0]  source_combine_select,
   input wire logic        direction_invert,
   input wire logic [15:0] maximum_frequency,
   input wire logic [15:0] combine_offset_frequency,
   input wire logic [15:0] analog_input_one,
   input wire logic [15:0] analog_input_two,
   input wire logic        freq_switch,
   input wire logic        up_pulse,
   input wire logic        down_pulse,
   input wire logic [15:0] updown_step,
   input wire logic [19:0] target_frequency,
   input wire logic        reverse_dir,
   input wire logic        config_error,
   input wire logic [15:0] digital_setting
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Scaled analog values and decoded selections
   wire [31:0] f1 = ({16'h0, analog_input_one} * maximum_frequency) / 32'd10000;
   wire [31:0] f2 = ({16'h0, analog_input_two} * maximum_frequency) / 32'd10000;
   wire [31:0] fs = f1 + f2 + {16'h0, combine_offset_frequency};
   wire [3:0]  un = source_combine_select[3:0];
   wire        same = main_source_select == aux_source_select;
   wire        an = main_source_select == 4'h2 && aux_source_select == 4'h3 && !analog_input_one[15]
                    && !analog_input_two[15];
   wire        dig = main_source_select == 4'h0 && aux_source_select != 4'h0 && un == 4'h0;
   reg  [1:0]  age_q;
   // Edges since reset release, saturating
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         age_q <= 2'h0;
      else if (age_q != 2'h3)
         age_q <= age_q + 2'h1;
   end
   property p_cfg;
      same |=> config_error && target_frequency == 20'h0 && !reverse_dir;
   endproperty
   a_cfg: assert property (p_cfg) else $error("clash not refused");
   property p_main;
      an && un == 4'h0 |=> target_frequency == $past(f1[19:0]);
   endproperty
   a_main: assert property (p_main) else $error("main value wrong");
   property p_dir;
      main_source_select == 4'h2 && !same && un == 4'h0 && analog_input_one != 16'h0
      && maximum_frequency >= 16'h2710 |=> reverse_dir == $past(analog_input_one[15] ^ direction_invert);
   endproperty
   a_dir: assert property (p_dir) else $error("direction wrong");
   property p_sum;
      an && un == 4'h1 && source_combine_select[7:4] == 4'h0 && !aux_range_base
      && aux_range_percent == 8'h64 |=> target_frequency == $past(fs[19:0]);
   endproperty
   a_sum: assert property (p_sum) else $error("sum wrong");
   property p_sw;
      an && un == 4'h2 |=> target_frequency == $past(freq_switch ? f2[19:0] : f1[19:0]);
   endproperty
   a_sw: assert property (p_sw) else $error("switchover wrong");
   property p_up;
      age_q == 2'h3 && dig && up_pulse && !down_pulse && 17'(digital_setting) + updown_step <= maximum_frequency
      |=> digital_setting == $past(digital_setting + updown_step);
   endproperty
   a_up: assert property (p_up) else $error("up step wrong");
   property p_both;
      age_q == 2'h3 && dig && up_pulse && down_pulse |=> $stable(digital_setting);
   endproperty
   a_both: assert property (p_both) else $error("up and down not ignored");
   property p_dig;
      $past(dig) |-> target_frequency == {4'h0, $past(digital_setting)};
   endproperty
   a_dig: assert property (p_dig) else $error("digital target wrong");
endmodule
bind frs_selector frs_chk chk
(
   .mclk, .rst, .main_source_select, .aux_source_select, .aux_range_base, .aux_range_percent,
   .source_combine_select, .direction_invert, .maximum_frequency, .combine_offset_frequency,
   .analog_input_one, .analog_input_two, .freq_switch, .up_pulse, .down_pulse, .updown_step,
   .target_frequency, .reverse_dir, .config_error, .digital_setting
);
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================
// Selector testbench
module tb;
   logic        mclk, rst, base, inv, slave, sw, up, dn, ld;
   logic [3:0]  msel, asel;
   logic [7:0]  pct, cmb;
   logic [15:0] pre, mx, off, step, ret, cv, val;
   logic [2:0]  idx;
   wire  [15:0] ch [0:6];
   wire  [19:0] tgt;
   wire  [15:0] dset;
   wire         rev, cerr;
   int          errors, comparisons;
   logic [7:0]  walk [8] = '{8'h00, 8'h01, 8'h11, 8'h21, 8'h31, 8'h02, 8'h03, 8'h04};

   frs_src_model src (.mclk(mclk), .rst(rst), .load(ld), .idx(idx), .value(val), .ch(ch));
   frs_selector dut
   (
      .mclk(mclk), .rst(rst), .main_source_select(msel), .aux_source_select(asel), .aux_range_base(base),
      .aux_range_percent(pct), .source_combine_select(cmb), .preset_frequency(pre), .direction_invert(inv),
      .maximum_frequency(mx), .combine_offset_frequency(off), .analog_input_one(ch[0]),
      .analog_input_two(ch[1]), .analog_input_three(ch[2]), .pulse_input_terminal(ch[3]),
      .multi_reference_pct(ch[4]), .sequencer_pct(ch[5]), .closed_loop_pct(ch[6]), .comm_value(cv),
      .comm_p2p_slave(slave), .freq_switch(sw), .up_pulse(up), .down_pulse(dn), .updown_step(step),
      .retained_frequency(ret), .target_frequency(tgt), .reverse_dir(rev), .config_error(cerr),
      .digital_setting(dset)
   );

   always #10 mclk = ~mclk;

   // Channel value as a signed frequency over a range
   function automatic longint fv(input logic [3:0] c, input longint rng);
      if (c == 4'h9)
         return slave ? longint'(cv) : $signed(cv) * rng / 10000;
      if (c >= 4'h2 && c <= 4'h8)
         return $signed(ch[c - 4'h2]) * rng / 10000;
      return 0;
   endfunction

   // Expected signed target
   function automatic longint ex();
      longint x, y, yi, c, r;
      x = fv(msel, mx);
      yi = fv(asel, mx);
      r = (base ? (x < 0 ? -x : x) : longint'(mx)) * longint'(pct > 8'd150 ? 8'd150 : pct) / 100;
      y = fv(asel, r);
      case (cmb[7:4])
         4'h0: c = x + y;
         4'h1: c = x - y;
         4'h2: c = (y * y > x * x) ? y : x;
         default: c = (y * y < x * x) ? y : x;
      endcase
      c = c + off;
      case (cmb[3:0])
         4'h0: return x;
         4'h1: return c;
         4'h2: return sw ? yi : x;
         4'h3: return sw ? c : x;
         default: return sw ? c : yi;
      endcase
   endfunction

   // Value and flag comparisons
   task automatic chkv(input logic [19:0] g, input logic [19:0] e);
      comparisons++;
      if (g !== e)
         $display("unexpected at %0t: value %0d want %0d", $time, g, e);
      errors += (g !== e);
   endtask
   task automatic chkb(input logic g, input logic e);
      comparisons++;
      if (g !== e)
         $display("unexpected at %0t: flag %b want %b", $time, g, e);
      errors += (g !== e);
   endtask

   // Stimulus helpers
   task automatic ld_ch(input int i, input int v);
      @(posedge mclk);
      ld <= 1'b1;
      idx <= 3'(i);
      val <= 16'(v);
   endtask
   task automatic settle();
      @(posedge mclk);
      ld <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic pulse(input logic u, input logic d);
      @(posedge mclk);
      up <= u;
      dn <= d;
      @(posedge mclk);
      up <= 1'b0;
      dn <= 1'b0;
      @(posedge mclk);
      #1;
   endtask
   task automatic check();
      longint e;
      e = (msel == asel) ? 0 : ex();
      chkb(cerr, msel == asel);
      chkv(tgt, 20'(e < 0 ? -e : e));
      chkb(rev, msel != asel && ((e < 0) ^ inv));
   endtask

   // Verdict and end of run
   task automatic results();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog
   initial
   begin
      #400000;
      errors++;
      results();
   end

   // Main sequence
   initial
   begin
      {mclk, rst, base, inv, slave, sw, up, dn, ld, idx, val} = '0;
      rst = 1'b1;
      {msel, asel, pct, cmb} = {4'h0, 4'h2, 8'h64, 8'h00};
      {pre, mx, off, step, ret, cv} = {16'h1388, 16'h2710, 16'h0, 16'h0064, 16'h04d2, 16'h0};
      void'($urandom(32'h332d));
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      chkv({4'h0, dset}, {4'h0, pre});
      pulse(1'b1, 1'b0);
      chkv(tgt, {4'h0, pre + step});
      pulse(1'b1, 1'b1);
      chkv({4'h0, dset}, {4'h0, pre + step});
      pulse(1'b0, 1'b1);
      chkv({4'h0, dset}, {4'h0, pre});
      @(posedge mclk);
      {msel, asel, cmb} <= {4'h2, 4'h0, 8'h01};
      pulse(1'b1, 1'b0);
      chkv(tgt, {4'h0, step});
      chkv({4'h0, dset}, {4'h0, pre});
      @(posedge mclk);
      rst <= 1'b1;
      msel <= 4'h1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      chkv({4'h0, dset}, {4'h0, ret});
      ld_ch(0, 5000);
      ld_ch(1, 10000);
      {msel, asel, off} <= {4'h2, 4'h3, 16'h0064};
      foreach (walk[i])
      begin
         cmb <= walk[i];
         sw <= i[0];
         settle();
         check();
      end
      repeat (150)
      begin
         for (int i = 0; i < 7; i++)
            ld_ch(i, int'($urandom_range(20000)) - 10000);
         msel <= 4'($urandom_range(9, 2));
         asel <= 4'($urandom_range(5, 2));
         cmb <= {4'($urandom_range(3)), 4'($urandom_range(4))};
         {base, inv, sw, slave} <= 4'($urandom);
         pct <= 8'($urandom_range(200));
         mx <= 16'($urandom_range(32000, 5000));
         off <= 16'($urandom_range(2000));
         cv <= 16'($urandom_range(10000));
         settle();
         check();
      end
      results();
   end
endmodule
`default_nettype wire
